//--- rtl/fmt_tick_div.v
// Shared base tick: one-cycle pulse every BASE_DIV clocks.
module fmt_tick_div #(
  parameter BASE_DIV = 8
) (
  input  wire ref_clk,
  input  wire nrst,
  input  wire stop,
  output reg  tick
);
  reg [7:0] cnt_q;
  always @(posedge ref_clk) begin
    if (!nrst || stop) begin
      cnt_q <= 8'h00;
      tick  <= 1'b0;
    end else if (cnt_q == BASE_DIV[7:0] - 8'h01) begin
      cnt_q <= 8'h00;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 8'h01;
      tick  <= 1'b0;
    end
  end
endmodule

//--- rtl/fmt_timer.v
`include "fmt_defines.vh"
// Four-channel match timer with byte/word register port.
module fmt_timer #(
  parameter NCH = 4
) (
  input  wire        ref_clk,
  input  wire        nrst,
  input  wire        sys_stop,
  input  wire [7:0]  addr,
  input  wire [15:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [15:0] rdata,
  output reg  [3:0]  chan_match_request,
  output reg         irq
);
  wire       base_tick;
  reg [15:0] cnt_q   [0:NCH-1];
  reg [15:0] con_q   [0:NCH-1];
  reg        flag_q  [0:NCH-1];
  reg        ien_q   [0:NCH-1];
  reg        run_q   [0:NCH-1];
  reg [2:0]  psc_q   [0:NCH-1];
  reg [7:0]  pdiv_q  [0:NCH-1];
  reg        armed_q [0:NCH-1];
  reg [3:0]  ist_q;
  reg [3:0]  imask_q;
  reg [NCH-1:0] hit;
  reg [NCH-1:0] cmp_eq;
  reg [NCH-1:0] cnt_wr;
  reg [NCH-1:0] con_wr;
  reg [NCH-1:0] csr_wr;
  reg [NCH-1:0] psc_wr;
  reg [NCH-1:0] cnt_rd;
  reg [NCH-1:0] csr_rd;
  reg [15:0]    rd_mux;
  // One loop variable per process keeps the drivers apart
  integer       i_dec;
  integer       i_psc;
  integer       i_cnt;
  integer       i_con;
  integer       i_csr;
  integer       i_flg;
  integer       i_req;
  integer       i_mux;
  integer       i_ist;

  // Stop mode clears the base tick divider too
  fmt_tick_div #(.BASE_DIV(`FMT_BASE_DIV)) u_div (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .stop    (sys_stop),
    .tick    (base_tick)
  );

  function sel;
    input [7:0] a;
    input integer ch;
    begin
      sel = (a[7:4] == ch[3:0]) && (ch < NCH);
    end
  endfunction

  function [7:0] pmask;
    input [2:0] s;
    begin
      pmask = (8'h01 << s) - 8'h01;
    end
  endfunction

  // Offset classes shared by write, read and flag logic
  function is_cnt;
    input [3:0] off;
    begin
      is_cnt = (off == `FMT_OFF_CNT_LO) || (off == `FMT_OFF_CNT_HI) ||
               (off == `FMT_OFF_CNT_W);
    end
  endfunction

  function is_con;
    input [3:0] off;
    begin
      is_con = (off == `FMT_OFF_CON_LO) || (off == `FMT_OFF_CON_HI) ||
               (off == `FMT_OFF_CON_W);
    end
  endfunction

  // Byte lanes: a byte access keeps the other half intact
  function [15:0] merge;
    input [15:0] old;
    input [15:0] wd;
    input [3:0]  off;
    input [3:0]  lo;
    input [3:0]  hi;
    begin
      if (off == lo)
        merge = {old[15:8], wd[7:0]};
      else if (off == hi)
        merge = {wd[7:0], old[7:0]};
      else
        merge = wd;
    end
  endfunction

  // Per-channel strobes, decoded once for every consumer
  always @* begin
    hit    = {NCH{1'b0}};
    cmp_eq = {NCH{1'b0}};
    cnt_wr = {NCH{1'b0}};
    con_wr = {NCH{1'b0}};
    csr_wr = {NCH{1'b0}};
    psc_wr = {NCH{1'b0}};
    cnt_rd = {NCH{1'b0}};
    csr_rd = {NCH{1'b0}};
    for (i_dec = 0; i_dec < NCH; i_dec = i_dec + 1) begin
      // Plain equality; each user adds its own run gating
      cmp_eq[i_dec] = (cnt_q[i_dec] == con_q[i_dec]);
      // Step when the masked part of the divider is all ones
      hit[i_dec] = run_q[i_dec] && base_tick &&
                   ((pdiv_q[i_dec] & pmask(psc_q[i_dec])) ==
                    pmask(psc_q[i_dec]));
      // Strobes stay low unless the address picks this channel
      cnt_wr[i_dec] = wr && sel(addr, i_dec) && is_cnt(addr[3:0]);
      con_wr[i_dec] = wr && sel(addr, i_dec) && is_con(addr[3:0]);
      csr_wr[i_dec] = wr && sel(addr, i_dec) &&
                      (addr[3:0] == `FMT_OFF_CSR);
      psc_wr[i_dec] = wr && sel(addr, i_dec) &&
                      (addr[3:0] == `FMT_OFF_PSC);
      cnt_rd[i_dec] = rd && sel(addr, i_dec) && is_cnt(addr[3:0]);
      csr_rd[i_dec] = rd && sel(addr, i_dec) &&
                      (addr[3:0] == `FMT_OFF_CSR);
    end
  end

  // Counter write restarts the prescaler, bounding the first step
  always @(posedge ref_clk) begin
    for (i_psc = 0; i_psc < NCH; i_psc = i_psc + 1) begin
      if (!nrst || sys_stop) begin
        pdiv_q[i_psc] <= 8'h00;
      end else if (cnt_wr[i_psc] || hit[i_psc]) begin
        pdiv_q[i_psc] <= 8'h00;
      end else if (run_q[i_psc] && base_tick) begin
        // Divider only advances while the channel runs
        pdiv_q[i_psc] <= pdiv_q[i_psc] + 8'h01;
      end
    end
  end

  // Host load wins over a step in the same cycle
  always @(posedge ref_clk) begin
    for (i_cnt = 0; i_cnt < NCH; i_cnt = i_cnt + 1) begin
      if (!nrst) begin
        cnt_q[i_cnt] <= `FMT_CNT_RST;
      end else if (sys_stop) begin
        // Stop freezes the count; flag, run and prescaler clear, constant reloads
        cnt_q[i_cnt] <= cnt_q[i_cnt];
      end else if (cnt_wr[i_cnt]) begin
        cnt_q[i_cnt] <= merge(cnt_q[i_cnt], wdata, addr[3:0],
                              `FMT_OFF_CNT_LO,
                              `FMT_OFF_CNT_HI);
      end else if (hit[i_cnt] && cmp_eq[i_cnt]) begin
        // Wrap on the step that finds the match
        cnt_q[i_cnt] <= 16'h0000;
      end else if (hit[i_cnt]) begin
        cnt_q[i_cnt] <= cnt_q[i_cnt] + 16'h0001;
      end
    end
  end

  // Constant is write-only; stop mode reloads all ones
  always @(posedge ref_clk) begin
    for (i_con = 0; i_con < NCH; i_con = i_con + 1) begin
      if (!nrst || sys_stop) begin
        con_q[i_con] <= `FMT_CON_RST;
      end else if (con_wr[i_con]) begin
        // Reads never reach this register
        con_q[i_con] <= merge(con_q[i_con], wdata, addr[3:0],
                              `FMT_OFF_CON_LO,
                              `FMT_OFF_CON_HI);
      end
    end
  end

  // Reserved control bits are never stored, so they read zero
  always @(posedge ref_clk) begin
    for (i_csr = 0; i_csr < NCH; i_csr = i_csr + 1) begin
      if (!nrst) begin
        ien_q[i_csr] <= 1'b0;
        run_q[i_csr] <= 1'b0;
        psc_q[i_csr] <= 3'h0;
      end else if (sys_stop) begin
        // Enable survives stop mode; only reset or a control write clears it
        run_q[i_csr] <= 1'b0;
      end else begin
        // Bits 5 and 3..0 of the write data are dropped
        if (csr_wr[i_csr]) begin
          ien_q[i_csr] <= wdata[`FMT_CSR_IEN];
          run_q[i_csr] <= wdata[`FMT_CSR_RUN];
        end
        if (psc_wr[i_csr]) begin
          psc_q[i_csr] <= wdata[2:0];
        end
      end
    end
  end

  // A status read seeing the flag arms the clear; a later counter
  // read clears it, with any accesses in between
  always @(posedge ref_clk) begin
    for (i_flg = 0; i_flg < NCH; i_flg = i_flg + 1) begin
      if (!nrst || sys_stop) begin
        flag_q[i_flg]  <= 1'b0;
        armed_q[i_flg] <= 1'b0;
      end else begin
        if (csr_rd[i_flg]) begin
          armed_q[i_flg] <= flag_q[i_flg];
        end
        // A held match keeps setting, so set wins over the clear
        if (cmp_eq[i_flg] && run_q[i_flg]) begin
          flag_q[i_flg] <= 1'b1;
        end else if (cnt_rd[i_flg] && armed_q[i_flg]) begin
          flag_q[i_flg]  <= 1'b0;
          armed_q[i_flg] <= 1'b0;
        end
      end
    end
  end

  // Registered so the request pins never glitch
  always @(posedge ref_clk) begin
    for (i_req = 0; i_req < NCH; i_req = i_req + 1) begin
      if (!nrst) begin
        chan_match_request[i_req] <= 1'b0;
      end else begin
        chan_match_request[i_req] <= flag_q[i_req] && ien_q[i_req];
      end
    end
  end

  // Read mux; unmapped and write-only offsets give zero
  always @* begin
    rd_mux = 16'h0000;
    for (i_mux = 0; i_mux < NCH; i_mux = i_mux + 1) begin
      if (sel(addr, i_mux)) begin
        case (addr[3:0])
          `FMT_OFF_CNT_LO: rd_mux = {8'h00, cnt_q[i_mux][7:0]};
          `FMT_OFF_CNT_HI: rd_mux = {8'h00, cnt_q[i_mux][15:8]};
          `FMT_OFF_CNT_W:  rd_mux = cnt_q[i_mux];
          `FMT_OFF_CSR: begin
            rd_mux = {8'h00, flag_q[i_mux], ien_q[i_mux], 1'b0,
                      run_q[i_mux], 4'h0};
          end
          `FMT_OFF_PSC:    rd_mux = {13'h0000, psc_q[i_mux]};
          default:         rd_mux = 16'h0000;
        endcase
      end
    end
    // Interrupt registers sit above the channel window
    if (addr == `FMT_OFF_ISTAT) begin
      rd_mux = {12'h000, ist_q};
    end
    if (addr == `FMT_OFF_IMASK) begin
      rd_mux = {12'h000, imask_q};
    end
  end

  // Data stands one cycle after the strobe, zero otherwise
  always @(posedge ref_clk) begin
    if (!nrst) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      rdata <= rd_mux;
    end else begin
      rdata <= 16'h0000;
    end
  end

  // Sticky match status; set wins over a write-one clear
  always @(posedge ref_clk) begin
    if (!nrst) begin
      ist_q   <= 4'h0;
      imask_q <= 4'h0;
      irq     <= 1'b0;
    end else begin
      for (i_ist = 0; i_ist < NCH; i_ist = i_ist + 1) begin
        // Only a running match that finds the flag still clear is an event
        if (!sys_stop && cmp_eq[i_ist] && run_q[i_ist] &&
            !flag_q[i_ist]) begin
          ist_q[i_ist] <= 1'b1;
        end else if (wr && (addr == `FMT_OFF_ISTAT) && wdata[i_ist]) begin
          ist_q[i_ist] <= 1'b0;
        end
      end
      // Mask shares the status layout
      if (wr && (addr == `FMT_OFF_IMASK)) begin
        imask_q <= wdata[3:0];
      end
      irq <= |(ist_q & imask_q);
    end
  end
endmodule

//--- shared/fmt_defines.vh
// Contract
// - Four identical channels, 16-bit counter, constant, status.
// - Base tick clk/8, then power-of-two prescale.
// - On match, counter clears and restarts.
// - Continuous compare sets compare match flag.
// - Request high while flag and enable set.
// - Host access never disturbs counting; writes load.
// - Constant write-only, all ones on reset/stop.
// - Flag clears on counter read after status read.
// - Flag cleared by reset and stop mode.
// - Bit 6 match interrupt enable, reset clears.
// - Bit 4 run enable, holds value, stop clears.
// - Bits 5 and 3..0 read zero.
// - Counter resets zero, high/low byte readable, writable.
`ifndef FMT_DEFINES_VH
`define FMT_DEFINES_VH
`define FMT_CLK_HZ        20000000
`define FMT_BASE_DIV      8
`define FMT_CH_STRIDE     8'h10
`define FMT_OFF_CNT_LO    4'h0
`define FMT_OFF_CNT_HI    4'h1
`define FMT_OFF_CON_LO    4'h2
`define FMT_OFF_CON_HI    4'h3
`define FMT_OFF_CSR       4'h4
`define FMT_OFF_PSC       4'h5
`define FMT_OFF_CNT_W     4'h6
`define FMT_OFF_CON_W     4'h7
`define FMT_OFF_ISTAT     8'h40
`define FMT_OFF_IMASK     8'h41
`define FMT_CSR_FLAG      7
`define FMT_CSR_IEN       6
`define FMT_CSR_RUN       4
`define FMT_CNT_RST       16'h0000
`define FMT_CON_RST       16'hFFFF
`endif

//--- tb/fmt_host.sv
module fmt_host (
  input  logic        ref_clk,
  input  logic [15:0] rdata,
  output logic [7:0]  addr,
  output logic [15:0] wdata,
  output logic        wr,
  output logic        rd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {addr, wdata, wr, rd} = '0;
  task put(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask
  task get(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
endmodule

//--- tb/fmt_timer_sva.sv
module fmt_chk (
  input logic        ref_clk,
  input logic        nrst,
  input logic        sys_stop,
  input logic [7:0]  addr,
  input logic [15:0] wdata,
  input logic        wr,
  input logic        rd,
  input logic [15:0] rdata,
  input logic [3:0]  chan_match_request,
  input logic        irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  wire act = rd | wr | sys_stop;
  wire chr = addr < 8'h40;
  sequence s_csr_set;
    rd && addr == 8'h04 ##1 rdata[7] && !rdata[4];
  endsequence
  sequence s_cnt_rd;
    rd && addr inside {8'h00, 8'h01, 8'h06};
  endsequence
  a_rdata_idle: assert property (!rd |=> rdata == 16'h0000)
    else $error("rdata not zero outside a read");
  a_csr_rsvd: assert property (rd && chr && addr[3:0] == 4'h4
    |=> (rdata & 16'hFF2F) == 16'h0000) else $error("csr reserved bit set");
  a_con_wo: assert property (rd && chr && addr[3:0] inside
    {4'h2, 4'h3, 4'h7} |=> rdata == 16'h0000) else $error("constant read");
  a_byte_rd: assert property (rd && chr && addr[3:1] == 3'h0
    |=> rdata[15:8] == 8'h00) else $error("byte read upper half");
  a_stop_quiet: assert property (sys_stop |=> ##1 !chan_match_request)
    else $error("request after stop");
  a_req_fall: assert property (|($past(chan_match_request) & ~chan_match_request)
    |-> $past(act) || $past(act, 2) || $past(act, 3)) else $error("request fell");
  a_irq_fall: assert property ($fell(irq)
    |-> $past(act) || $past(act, 2) || $past(act, 3)) else $error("irq fell");
  a_flag_clear: assert property (s_csr_set ##[0:6] s_cnt_rd
    |=> ##2 !chan_match_request[0]) else $error("flag not cleared");
endmodule

bind fmt_timer fmt_chk u_chk (.ref_clk(ref_clk), .nrst(nrst),
  .sys_stop(sys_stop), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .chan_match_request(chan_match_request), .irq(irq));

//--- tb/fmt_timer_tb.sv
module fmt_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, nrst = 0, sys_stop = 0, wr, rd, irq;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, d;
  logic [3:0] chan_match_request;
  int fail_count = 0, n_checks = 0, cyc = 0;
  always #25 ref_clk = ~ref_clk;
  fmt_host u_host (.ref_clk(ref_clk), .rdata(rdata), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd));
  fmt_timer u_dut (.ref_clk(ref_clk), .nrst(nrst), .sys_stop(sys_stop),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .chan_match_request(chan_match_request), .irq(irq));
  task chk(string n, logic [15:0] e, logic [15:0] s);
    n_checks++;
    if (s !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, s);
      fail_count++;
    end
  endtask
  task rchk(logic [7:0] a, logic [15:0] e, string n);
    u_host.get(a, d);
    chk(n, e, d);
  endtask
  task t_reset;
    rchk(8'h04, 16'h0000, "csr");
    rchk(8'h06, 16'h0000, "count");
  endtask
  task t_bytes;
    u_host.put(8'h10, 16'h0034);
    u_host.put(8'h11, 16'h0012);
    rchk(8'h16, 16'h1234, "word");
    u_host.put(8'h10, 16'h00AB);
    rchk(8'h16, 16'h12AB, "low byte");
    u_host.put(8'h14, 16'h0050);
    rchk(8'h14, 16'h0050, "csr bits");
    u_host.put(8'h14, 16'h0000);
  endtask
  task t_match;
    u_host.put(8'h07, 16'h0003);
    u_host.put(8'h04, 16'h0050);
    for (int i = 0; i < 400 && chan_match_request[0] !== 1'b1; i++)
      @(posedge ref_clk);
    chk("request", 16'h1, chan_match_request[0]);
    chk("masked irq", 16'h0, irq);
    u_host.put(8'h41, 16'h0001);
    repeat (3) @(posedge ref_clk);
    chk("irq", 16'h1, irq);
    u_host.get(8'h06, d);
    chk("wrap", 16'h1, d <= 16'h0003);
    u_host.put(8'h04, 16'h0040);
    rchk(8'h04, 16'h00C0, "flag");
    u_host.get(8'h00, d);
    u_host.put(8'h40, 16'h000F);
    repeat (3) @(posedge ref_clk);
    chk("cleared", 16'h0, {chan_match_request[0], irq});
  endtask
  task t_load;
    u_host.put(8'h34, 16'h0010);
    u_host.put(8'h36, 16'h0100);
    repeat (10) @(posedge ref_clk);
    u_host.get(8'h36, d);
    chk("load start", 16'h1, d >= 16'h0101 && d <= 16'h0102);
    u_host.put(8'h34, 16'h0000);
  endtask
  task t_psc;
    u_host.put(8'h25, 16'h0002);
    u_host.put(8'h26, 16'h0000);
    u_host.put(8'h24, 16'h0010);
    repeat (320) @(posedge ref_clk);
    u_host.get(8'h26, d);
    chk("steps", 16'h1, d >= 16'h0009 && d <= 16'h000A);
    u_host.put(8'h24, 16'h0000);
    u_host.get(8'h26, d);
    repeat (100) @(posedge ref_clk);
    rchk(8'h26, d, "held");
    u_host.put(8'h24, 16'h0050);
    sys_stop <= 1'b1;
    @(posedge ref_clk);
    sys_stop <= 1'b0;
    rchk(8'h24, 16'h0040, "stop csr");
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      summarize;
    end
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset;
    t_bytes;
    t_match;
    t_load;
    t_psc;
    summarize;
  end
endmodule
